// ===== rtl/clb_logic_block.sv
// One logic block with sixteen macrocells, programmed over APB.
//
// Local design decisions: the APB interface to the registers and the register addresses.
`include "clb_regs.svh"
`default_nettype none
module clb_logic_block
  import clb_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire clb_apb_req_t apb_req,
  output var clb_apb_rsp_t apb_rsp,
  // Interconnect side.
  input wire logic [35:0] gia_in,
  output var logic [31:0] gia_fb,
  // Macrocell pins.
  input wire logic [15:0] io_in,
  output var logic [15:0] io_out,
  output var logic [15:0] io_oe_n,
  // Global clock and three-state pins.
  input wire logic global_clock_sync_only,
  input wire logic global_clock_one,
  input wire logic global_clock_two,
  input wire logic global_clock_three,
  input wire logic global_three_state_pin_n
);
  localparam int NT = `CLB_N_TERM;
  localparam int NM = `CLB_N_MC;

  // Configuration and state.
  clb_term_t term_q [NT];
  clb_term_t term_d [NT];
  logic [31:0] or_q [NM];
  logic [31:0] or_d [NM];
  clb_mode_t mode_q [NM];
  clb_mode_t mode_d [NM];
  logic [15:0] glob_q, glob_d;
  logic [5:0] ct_type_q, ct_type_d;
  logic [15:0] mc_q, mc_d;
  logic [15:0] oe_n_q, oe_n_d;
  logic [3:0] gclk_prev_q, gclk_prev_d;
  logic [20:0] sync1_q, sync1_d, sync2_q, sync2_d;
  clb_apb_rsp_t rsp_q, rsp_d;

  // Derived signals.
  logic [NT-1:0] term_v;
  logic [15:0] sum_v, evt_v, pr_en_v, toggle_v, oe_want_v;
  logic [3:0] gsrc, rise_v, fall_v;
  logic [5:0] ct_v;
  logic [15:0] pin_v;
  logic [3:0] gclk_sync;
  logic tri_force;
  logic setup, wr_en;
  logic [11:0] addr;
  logic [6:0] tidx;
  logic [31:0] wdata;

  // Pin levels pass two flip-flops before any logic reads them.
  always_comb begin
    sync1_d = {global_three_state_pin_n, global_clock_three, global_clock_two,
               global_clock_one, global_clock_sync_only, io_in};
    sync2_d = sync1_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 21'h100000; // Three-state pin idles high, so reset gives no false force.
      sync2_q <= 21'h100000;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
    end
  end

  assign pin_v = sync2_q[15:0];
  assign gclk_sync = sync2_q[19:16];
  assign tri_force = glob_q[`CLB_GLB_TRI_EN_BIT] & ~sync2_q[20];

  // Bus decode helpers.
  assign addr = apb_req.paddr;
  assign tidx = addr[10:4];
  assign wdata = apb_req.pwdata;
  assign setup = apb_req.psel & ~apb_req.penable;
  assign wr_en = apb_req.psel & apb_req.penable & rsp_q.pready & apb_req.pwrite;

  // Every term of the block: five per macrocell, the shared pool, then the control terms.
  for (genvar t = 0; t < NT; t++) begin : g_term
    if (t >= `CLB_CT_FIRST) begin : g_ct
      clb_pterm u_term (
        .lits(gia_in),
        .cfg(term_q[t]),
        .sum_mode(ct_type_q[t-`CLB_CT_FIRST]),
        .term(term_v[t])
      );
    end else begin : g_pt
      clb_pterm u_term (
        .lits(gia_in),
        .cfg(term_q[t]),
        .sum_mode(1'b0),
        .term(term_v[t])
      );
    end
  end

  assign ct_v = term_v[`CLB_CT_FIRST +: `CLB_N_CT];

  // Register writes, taken at the edge that completes an APB write.
  always_comb begin
    term_d = term_q;
    or_d = or_q;
    mode_d = mode_q;
    glob_d = glob_q;
    ct_type_d = ct_type_q;
    if (wr_en) begin
      if (addr < `CLB_MC_OR_BASE) begin
        if (tidx < 7'(NT)) begin
          if (addr[3:2] == `CLB_TW_TRUE) begin
            term_d[tidx].tmask[31:0] = wdata;
          end else if (addr[3:2] == `CLB_TW_COMP) begin
            term_d[tidx].cmask[31:0] = wdata;
          end else if (addr[3:2] == `CLB_TW_HIGH) begin
            term_d[tidx].tmask[35:32] = wdata[`CLB_TW_THI_LSB +: 4];
            term_d[tidx].cmask[35:32] = wdata[`CLB_TW_CHI_LSB +: 4];
            term_d[tidx].en = wdata[`CLB_TW_EN_BIT];
          end
        end
      end else if (addr < `CLB_MC_MODE_BASE) begin
        or_d[addr[5:2]] = wdata;
      end else if (addr < `CLB_GLOBAL_CFG) begin
        mode_d[addr[5:2]] = wdata[7:0];
      end else if (addr == `CLB_GLOBAL_CFG) begin
        glob_d = wdata[15:0];
      end else if (addr == `CLB_CT_TYPE) begin
        ct_type_d = wdata[5:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NT; i++) begin
        term_q[i] <= '0;
      end
      for (int i = 0; i < NM; i++) begin
        or_q[i] <= 32'h00000000;
        mode_q[i] <= `CLB_MODE_RESET;
      end
      glob_q <= `CLB_GLB_RESET;
      ct_type_q <= `CLB_CT_RESET;
    end else begin
      term_q <= term_d;
      or_q <= or_d;
      mode_q <= mode_d;
      glob_q <= glob_d;
      ct_type_q <= ct_type_d;
    end
  end

  // APB answer: ready in the access phase, data and error set up one cycle ahead.
  always_comb begin
    rsp_d = '0;
    if (setup) begin
      rsp_d.pready = 1'b1;
      if (addr < `CLB_MC_OR_BASE) begin
        if (tidx >= 7'(NT) || addr[3:2] == 2'h3) begin
          rsp_d.pslverr = 1'b1;
        end else if (addr[3:2] == `CLB_TW_TRUE) begin
          rsp_d.prdata = term_q[tidx].tmask[31:0];
        end else if (addr[3:2] == `CLB_TW_COMP) begin
          rsp_d.prdata = term_q[tidx].cmask[31:0];
        end else begin
          rsp_d.prdata = {23'h000000, term_q[tidx].en, term_q[tidx].tmask[35:32], term_q[tidx].cmask[35:32]};
        end
      end else if (addr < `CLB_MC_MODE_BASE) begin
        rsp_d.prdata = or_q[addr[5:2]];
      end else if (addr < `CLB_GLOBAL_CFG) begin
        rsp_d.prdata = {24'h000000, mode_q[addr[5:2]]};
      end else if (addr == `CLB_GLOBAL_CFG) begin
        rsp_d.prdata = {16'h0000, glob_q};
      end else if (addr == `CLB_CT_TYPE) begin
        rsp_d.prdata = {26'h0000000, ct_type_q};
      end else if (addr == `CLB_MC_STATE) begin
        rsp_d.prdata = {16'h0000, mc_q};
        rsp_d.pslverr = apb_req.pwrite;
      end else if (addr == `CLB_PIN_STATE) begin
        rsp_d.prdata = {16'h0000, pin_v};
        rsp_d.pslverr = apb_req.pwrite;
      end else begin
        rsp_d.pslverr = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsp_q <= '0;
    end else begin
      rsp_q <= rsp_d;
    end
  end

  assign apb_rsp = rsp_q;

  // Global clock levels; clock zero always comes from its pin.
  always_comb begin
    gsrc[0] = gclk_sync[0];
    for (int c = 1; c < 4; c++) begin
      gsrc[c] = glob_q[`CLB_GLB_SRC_LSB + c - 1] ? mc_q[glob_q[4*c +: 4]] : gclk_sync[c];
    end
    gclk_prev_d = gsrc;
    rise_v = gsrc & ~gclk_prev_q;
    fall_v = ~gsrc & gclk_prev_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gclk_prev_q <= 4'h0;
    end else begin
      gclk_prev_q <= gclk_prev_d;
    end
  end

  // Macrocell logic: sum of terms, clocking, preset and reset, output enable.
  always_comb begin
    for (int i = 0; i < NM; i++) begin
      sum_v[i] = |term_v[i*`CLB_N_OWN +: `CLB_N_OWN] |
                 |(term_v[`CLB_SHARED_FIRST +: `CLB_N_SHARED] & or_q[i]);
      evt_v[i] = mode_q[i].fall ? fall_v[mode_q[i].clk_sel] : rise_v[mode_q[i].clk_sel];
      pr_en_v[i] = mode_q[i].pr_en;
      toggle_v[i] = mode_q[i].toggle;
      if (pr_en_v[i] && ct_v[`CLB_CT_RST]) begin
        mc_d[i] = 1'b0;
      end else if (pr_en_v[i] && ct_v[`CLB_CT_SET]) begin
        mc_d[i] = 1'b1;
      end else if (evt_v[i]) begin
        mc_d[i] = toggle_v[i] ? (mc_q[i] ^ sum_v[i]) : sum_v[i];
      end else begin
        mc_d[i] = mc_q[i];
      end
      if (mode_q[i].oe_sel < `CLB_OE_ALWAYS_ON) begin
        oe_want_v[i] = ct_v[`CLB_CT_OE_FIRST + 32'(mode_q[i].oe_sel)];
      end else begin
        oe_want_v[i] = (mode_q[i].oe_sel == `CLB_OE_ALWAYS_ON);
      end
      oe_n_d[i] = ~(oe_want_v[i] & ~tri_force);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mc_q <= 16'h0000;
      oe_n_q <= 16'hFFFF;
    end else begin
      mc_q <= mc_d;
      oe_n_q <= oe_n_d;
    end
  end

  // Pins carry the flip-flops; feedback pairs the logic value with the pin level.
  assign io_out = mc_q;
  assign io_oe_n = oe_n_q;
  assign gia_fb = {pin_v, mc_q};

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_tri_low;
    tri_force;
  endsequence

  sequence s_all_off;
    io_oe_n == 16'hFFFF;
  endsequence

  chk_tri_forces_off: assert property (s_tri_low |=> s_all_off)
    else $error("Global three-state did not turn every output off.");

  chk_reset_priority: assert property (ct_v[`CLB_CT_RST] |=> (mc_q & $past(pr_en_v)) == 16'h0000)
    else $error("Reset term did not clear enabled macrocells.");

  chk_preset_sets: assert property (ct_v[`CLB_CT_SET] && !ct_v[`CLB_CT_RST]
      |=> (mc_q & $past(pr_en_v)) == $past(pr_en_v))
    else $error("Preset term did not set enabled macrocells.");

  chk_hold_no_edge: assert property (1'b1 |=> ((mc_q ^ $past(mc_q)) &
      ~$past(evt_v | (pr_en_v & {16{ct_v[`CLB_CT_RST] | ct_v[`CLB_CT_SET]}}))) == 16'h0000)
    else $error("Macrocell changed without a clock edge or active preset.");

  chk_d_capture: assert property (1'b1 |=> ((mc_q ^ $past(sum_v)) &
      $past(evt_v & ~toggle_v & ~(pr_en_v & {16{|ct_v[1:0]}}))) == 16'h0000)
    else $error("D macrocell did not capture its sum on the edge.");

  chk_t_toggle: assert property (1'b1 |=> ((mc_q ^ ~$past(mc_q)) &
      $past(evt_v & toggle_v & sum_v & ~(pr_en_v & {16{|ct_v[1:0]}}))) == 16'h0000)
    else $error("Toggle macrocell did not flip on the edge.");

  chk_oe_fixed: assert property (!tri_force |=> ((io_oe_n ^ ~$past(oe_want_v)) == 16'h0000))
    else $error("Output enable does not follow its selected source.");

  chk_oe_term: assert property (!tri_force && mode_q[5].oe_sel == 3'h0 ##1 1'b1
      |-> io_oe_n[5] == ~$past(ct_v[`CLB_CT_OE_FIRST]))
    else $error("Output enable of macrocell five ignored its control term.");

  chk_por_zero: assert property ($rose(presetn) |-> mc_q == 16'h0000)
    else $error("Macrocells not zero after reset.");
endmodule : clb_logic_block
`default_nettype wire

// ===== rtl/clb_pkg.sv
// Types shared by the logic block modules.
`default_nettype none
package clb_pkg;
  // One product or control term: enable plus true and complement literal masks.
  typedef struct packed {
    logic en;
    logic [35:0] tmask;
    logic [35:0] cmask;
  } clb_term_t;
  // Per macrocell mode byte, low bit first: toggle, falling edge, clock, preset enable, output enable source.
  typedef struct packed {
    logic [2:0] oe_sel;
    logic pr_en;
    logic [1:0] clk_sel;
    logic fall;
    logic toggle;
  } clb_mode_t;
  // APB request from the master.
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } clb_apb_req_t;
  // APB answer to the master.
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } clb_apb_rsp_t;
endpackage : clb_pkg
`default_nettype wire

// ===== rtl/clb_pterm.sv
// One programmable term of the logic block, as an AND or an OR of literals.
`default_nettype none
module clb_pterm
  import clb_pkg::*;
(
  // Literals from the interconnect.
  input wire logic [35:0] lits,
  // Term programming.
  input wire clb_term_t cfg,
  input wire logic sum_mode,
  // Result.
  output logic term
);
  logic prod_v;
  logic sum_v;

  // A disabled term reads low in both modes.
  always_comb begin
    prod_v = &(~cfg.tmask | lits) & &(~cfg.cmask | ~lits);
    sum_v = |(cfg.tmask & lits) | |(cfg.cmask & ~lits);
    term = cfg.en & (sum_mode ? sum_v : prod_v);
  end
endmodule : clb_pterm
`default_nettype wire

// ===== rtl/clb_regs.svh
// Register offsets, field positions and reset values of the logic block.
`ifndef CLB_REGS_SVH
`define CLB_REGS_SVH
`define CLB_N_IN 36
`define CLB_N_MC 16
`define CLB_N_OWN 5
`define CLB_N_SHARED 32
`define CLB_N_CT 6
`define CLB_N_TERM 118
`define CLB_SHARED_FIRST 80
`define CLB_CT_FIRST 112
`define CLB_ADDR_W 12
`define CLB_MC_OR_BASE 12'h800
`define CLB_MC_MODE_BASE 12'h840
`define CLB_GLOBAL_CFG 12'h880
`define CLB_CT_TYPE 12'h884
`define CLB_MC_STATE 12'h888
`define CLB_PIN_STATE 12'h88C
`define CLB_TW_TRUE 2'h0
`define CLB_TW_COMP 2'h1
`define CLB_TW_HIGH 2'h2
`define CLB_TW_EN_BIT 8
`define CLB_TW_THI_LSB 4
`define CLB_TW_CHI_LSB 0
`define CLB_MODE_RESET 8'hA0
`define CLB_OE_ALWAYS_ON 3'h4
`define CLB_GLB_TRI_EN_BIT 0
`define CLB_GLB_SRC_LSB 1
`define CLB_GLB_RESET 16'h0000
`define CLB_CT_RESET 6'h00
`define CLB_CT_RST 0
`define CLB_CT_SET 1
`define CLB_CT_OE_FIRST 2
`endif

// ===== test/clb_board.sv
// Board model that resolves the macrocell pins and supplies clock zero.
`default_nettype none
module clb_board (
  // Device side.
  input wire logic [15:0] io_out,
  input wire logic [15:0] io_oe_n,
  output logic [15:0] io_in,
  output logic sync_clk,
  // Bench side.
  input wire logic [15:0] drv,
  input wire logic sync_clk_req
);
  timeunit 1ns;
  timeprecision 1ps;
  // The device wins on enabled pins; the board drives every released pin.
  assign io_in = (~io_oe_n & io_out) | (io_oe_n & drv);
  // Clock zero is only ever made outside the device.
  assign sync_clk = sync_clk_req;
endmodule : clb_board
`default_nettype wire

// ===== test/tb_top.sv
// Self-checking bench of the logic block.
`default_nettype none
module tb_top
  import clb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  clb_apb_req_t req = '0;
  clb_apb_rsp_t rsp;
  logic [35:0] gia_in = '0;
  logic [31:0] gia_fb;
  logic [15:0] io_in;
  logic [15:0] io_out;
  logic [15:0] io_oe_n;
  logic [15:0] drv = '0;
  logic sync_clk_req = 1'b0;
  logic tri_pin_n = 1'b1;
  logic [2:0] ext_clk = '0;
  wire logic sync_clk;
  int miscompares = 0;
  int num_checks = 0;
  int cyc = 0;
  int seed = 63235;
  logic [33:0] exp_q[$];
  logic [33:0] e;

  // Design and board.
  clb_logic_block dut_u (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp), .gia_in(gia_in),
    .gia_fb(gia_fb), .io_in(io_in), .io_out(io_out), .io_oe_n(io_oe_n), .global_clock_sync_only(sync_clk),
    .global_clock_one(ext_clk[0]), .global_clock_two(ext_clk[1]), .global_clock_three(ext_clk[2]),
    .global_three_state_pin_n(tri_pin_n));
  clb_board board_u (.io_out(io_out), .io_oe_n(io_oe_n), .io_in(io_in), .sync_clk(sync_clk), .drv(drv),
    .sync_clk_req(sync_clk_req));

  // Clock of 4 ns.
  always #2 pclk = ~pclk;

  task automatic chk(input string n, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, exp, got);
    end
  endtask : chk

  task automatic finish_test;
    if (exp_q.size() != 0) begin
      miscompares++;
    end
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test

  task automatic cy(input int n);
    repeat (n) @(posedge pclk);
  endtask : cy

  // One APB transfer; the expected answer goes to the queue first.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic ee);
    exp_q.push_back({~wr, ee, d});
    @(posedge pclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge pclk);
    req.penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (rsp.pready !== 1'b1);
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  // Program one term: true mask, complement mask, then enable word.
  task automatic term(input int idx, input logic [35:0] t, input logic [35:0] c);
    logic [11:0] b;
    b = 12'(idx * 16);
    apb(1'b1, b, t[31:0], 1'b0);
    apb(1'b1, b + 12'h004, c[31:0], 1'b0);
    apb(1'b1, b + 12'h008, {23'h000000, 1'b1, t[35:32], c[35:32]}, 1'b0);
  endtask : term

  task automatic mode(input int m, input logic [7:0] v);
    apb(1'b1, 12'h840 + 12'(m * 4), {24'h000000, v}, 1'b0);
  endtask : mode

  task automatic setc(input logic v);
    sync_clk_req <= v;
    cy(5);
  endtask : setc

  // Answer watcher and run limit.
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 20000) begin
      miscompares++;
      finish_test();
    end
    if (presetn && req.psel && req.penable && rsp.pready === 1'b1) begin
      e = exp_q.pop_front();
      chk("pslverr", {31'h00000000, e[32]}, {31'h00000000, rsp.pslverr});
      if (e[33]) begin
        chk("prdata", e[31:0], rsp.prdata);
      end
    end
  end

  // Main sequence.
  initial begin
    cy(4);
    presetn <= 1'b1;
    gia_in[35:8] <= 28'($random(seed));
    drv <= 16'($random(seed));
    cy(6);
    chk("io_out", 32'h0, {16'h0, io_out});
    chk("io_oe_n", 32'hFFFF, {16'h0, io_oe_n});
    chk("fb logic", 32'h0, {16'h0, gia_fb[15:0]});
    chk("fb pins", {16'h0, drv}, {16'h0, gia_fb[31:16]});
    apb(1'b0, 12'h840, 32'h000000A0, 1'b0);
    apb(1'b0, 12'h884, 32'h0, 1'b0);
    apb(1'b0, 12'h890, 32'h0, 1'b1);
    apb(1'b1, 12'h888, 32'h5, 1'b1);
    apb(1'b1, 12'h00C, 32'h1, 1'b1);
    apb(1'b1, 12'h760, 32'h1, 1'b1);
    // Own terms, shared terms and complement literals.
    term(0, 36'h1, 36'h0);
    apb(1'b0, 12'h000, 32'h1, 1'b0);
    term(80, 36'h2, 36'h0);
    apb(1'b1, 12'h804, 32'h1, 1'b0);
    apb(1'b1, 12'h808, 32'h1, 1'b0);
    term(40, 36'h0, 36'h20);
    term(20, 36'h0, 36'h0);
    mode(0, 8'h80);
    mode(1, 8'h80);
    mode(2, 8'h80);
    mode(8, 8'h80);
    mode(4, 8'h82);
    gia_in[1:0] <= 2'h3;
    setc(1'b1);
    chk("falling", 32'h0, {31'h0, io_out[4]});
    setc(1'b0);
    chk("falling", 32'h1, {31'h0, io_out[4]});
    chk("d and shared", 32'h117, {23'h0, io_out[8:0]});
    chk("oe on", 32'h0, {31'h0, io_oe_n[0]});
    chk("fb pair", 32'h3, {30'h0, gia_fb[16], gia_fb[0]});
    // Toggle macrocell three clocks macrocell six.
    term(15, 36'h0, 36'h0);
    term(30, 36'h0, 36'h0);
    mode(3, 8'h81);
    mode(6, 8'h85);
    apb(1'b1, 12'h880, 32'h32, 1'b0);
    setc(1'b1);
    setc(1'b0);
    chk("toggle", 32'h3, {30'h0, io_out[6], io_out[3]});
    setc(1'b1);
    setc(1'b0);
    chk("toggle", 32'h2, {30'h0, io_out[6], io_out[3]});
    // Reset beats preset without any clock edge.
    mode(0, 8'h90);
    term(113, 36'h0, 36'h0);
    gia_in[2] <= 1'b1;
    term(112, 36'h4, 36'h0);
    cy(3);
    chk("reset", 32'h2, {30'h0, io_out[1:0]});
    gia_in[2] <= 1'b0;
    cy(3);
    chk("preset", 32'h3, {30'h0, io_out[1:0]});
    // Sum control term as output enable of macrocell five.
    apb(1'b1, 12'h884, 32'h4, 1'b0);
    term(114, 36'h18, 36'h0);
    mode(5, 8'h00);
    cy(3);
    chk("oe term", 32'h1, {31'h0, io_oe_n[5]});
    gia_in[3] <= 1'b1;
    cy(3);
    chk("oe sum", 32'h0, {31'h0, io_oe_n[5]});
    chk("input pin", {31'h0, drv[7]}, {31'h0, gia_fb[23]});
    // Global three-state only when enabled.
    tri_pin_n <= 1'b0;
    cy(5);
    chk("tri off", 32'h0, {31'h0, io_oe_n[0]});
    apb(1'b1, 12'h880, 32'h33, 1'b0);
    cy(5);
    chk("tri on", 32'hFFFF, {16'h0, io_oe_n});
    tri_pin_n <= 1'b1;
    cy(5);
    chk("tri released", 32'h0, {31'h0, io_oe_n[0]});
    // Clock two taken from its own pin clocks macrocell nine.
    term(45, 36'h0, 36'h0);
    mode(9, 8'h88);
    chk("pin clock idle", 32'h0, {31'h0, io_out[9]});
    ext_clk[1] <= 1'b1;
    cy(5);
    chk("pin clock", 32'h1, {31'h0, io_out[9]});
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
